// >>> ocs_cfg.svh
// Constants for the command and status register block
`ifndef OCS_CFG_SVH
`define OCS_CFG_SVH

`define OCS_REG_OFFSET      8'h08
`define OCS_RESET_VALUE     32'h0000_0000
`define OCS_BIT_SOFT_RESET  0
`define OCS_BIT_CTRL_FILLED 1
`define OCS_BIT_BULK_FILLED 2
`define OCS_BIT_OWNER_REQ   3
`define OCS_TALLY_LSB       16
`define OCS_TALLY_MSB       17
`define OCS_RESET_LIMIT_NS  10000
`define OCS_CLK_PERIOD_NS   20
`define OCS_RESET_CYCLES    ((`OCS_RESET_LIMIT_NS) / (`OCS_CLK_PERIOD_NS))
`define OCS_RESET_DEFAULT   16

`endif

// >>> ocs_pkg.sv
// Types for the command and status register block
package ocs_pkg;
  typedef enum logic [1:0] {
    OCS_RST_IDLE,
    OCS_RST_RUN,
    OCS_RST_DONE
  } ocs_rst_state_t;
endpackage : ocs_pkg

// >>> ocs_soft_reset.sv
// Soft reset sequencer: holds the controller in reset for a set number of cycles
`timescale 1ns/1ps
`include "ocs_cfg.svh"

module ocs_soft_reset #(
  parameter int RESET_CYCLES = `OCS_RESET_DEFAULT
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic start,
  output logic      resetActive,
  output logic      resetDone
);

  initial begin
    if (RESET_CYCLES < 1 || RESET_CYCLES > `OCS_RESET_CYCLES) begin
      $error("RESET_CYCLES must be between 1 and the 10 us limit in cycles");
    end
  end

  ocs_pkg::ocs_rst_state_t stateQ;
  ocs_pkg::ocs_rst_state_t stateD;
  logic [15:0]             countQ;
  logic [15:0]             countD;

  wire countEnd = (countQ == 16'(RESET_CYCLES - 1));

  always_comb begin
    stateD = stateQ;
    countD = countQ;
    unique case (stateQ)
      ocs_pkg::OCS_RST_IDLE: begin
        countD = 16'h0000;
        if (start) begin
          stateD = ocs_pkg::OCS_RST_RUN;
        end
      end
      ocs_pkg::OCS_RST_RUN: begin
        countD = countQ + 16'h0001;
        if (countEnd) begin
          stateD = ocs_pkg::OCS_RST_DONE;
        end
      end
      ocs_pkg::OCS_RST_DONE: begin
        // A new request in the closing cycle starts a fresh count
        countD = 16'h0000;
        stateD = start ? ocs_pkg::OCS_RST_RUN : ocs_pkg::OCS_RST_IDLE;
      end
      default: begin
        stateD = ocs_pkg::OCS_RST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stateQ <= ocs_pkg::OCS_RST_IDLE;
      countQ <= 16'h0000;
    end else begin
      stateQ <= stateD;
      countQ <= countD;
    end
  end

  assign resetActive = (stateQ == ocs_pkg::OCS_RST_RUN);
  assign resetDone   = (stateQ == ocs_pkg::OCS_RST_DONE);

endmodule : ocs_soft_reset

// >>> ocs_command_status.sv
// Command and status register of the open host controller
`timescale 1ns/1ps
`include "ocs_cfg.svh"

module ocs_command_status #(
  parameter int RESET_CYCLES = `OCS_RESET_DEFAULT
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        regWrite,
  input  wire logic [31:0] regWdata,
  output logic      [31:0] regRdata,
  input  wire logic        frameEnd,
  input  wire logic        periodicDone,
  input  wire logic        handoverDone,
  input  wire logic        bulkHeadCheck,
  input  wire logic        bulkTdFound,
  input  wire logic        bulkPassEnd,
  input  wire logic        ctrlHeadCheck,
  input  wire logic        ctrlTdFound,
  input  wire logic        ctrlPassEnd,
  output logic             bulkProcess,
  output logic             ctrlProcess,
  output logic             overrunEvent,
  output logic             ownerChangeEvent,
  output logic             softResetActive,
  output logic             hostBusBlock,
  output logic             suspendedEnter,
  output logic             rootHubReset
);

  initial begin
    if (RESET_CYCLES < 1) begin
      $error("RESET_CYCLES must be at least one");
    end
  end

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [1:0] tallyQ;
  logic       ownerReqQ;
  logic       bulkFilledQ;
  logic       ctrlFilledQ;
  logic       softResetQ;
  logic       bulkRunQ;
  logic       ctrlRunQ;
  logic       overrunQ;
  logic       ownerEvtQ;
  logic       resetActive;
  logic       resetDone;

  // ****************************************************************
  // Decoding
  // ****************************************************************
  wire wrOwner    = regWrite && regWdata[`OCS_BIT_OWNER_REQ];
  wire wrBulk     = regWrite && regWdata[`OCS_BIT_BULK_FILLED];
  wire wrCtrl     = regWrite && regWdata[`OCS_BIT_CTRL_FILLED];
  wire wrReset    = regWrite && regWdata[`OCS_BIT_SOFT_RESET];
  wire overrunHit = frameEnd && !periodicDone;
  wire ownerRise  = wrOwner && !ownerReqQ;
  // A write landing on the completion cycle keeps the bit set, so it must also restart the sequence
  wire resetStart = wrReset && (!softResetQ || resetDone);

  // Soft reset clears list flags; a driver set in the same cycle still wins
  wire bulkClear  = bulkHeadCheck && bulkFilledQ;
  wire ctrlClear  = ctrlHeadCheck && ctrlFilledQ;
  wire bulkSet    = wrBulk || (bulkRunQ && bulkTdFound);
  wire ctrlSet    = wrCtrl || (ctrlRunQ && ctrlTdFound);

  wire [1:0] tallyD       = overrunHit ? tallyQ + 2'h1 : tallyQ;
  wire       ownerReqD    = wrOwner ? 1'b1 : (handoverDone ? 1'b0 : ownerReqQ);
  wire       bulkFilledD  = bulkSet ? 1'b1 : ((bulkClear || resetActive) ? 1'b0 : bulkFilledQ);
  wire       ctrlFilledD  = ctrlSet ? 1'b1 : ((ctrlClear || resetActive) ? 1'b0 : ctrlFilledQ);
  wire       softResetD   = wrReset ? 1'b1 : (resetDone ? 1'b0 : softResetQ);

  // Bulk run starts at a filled head, ends when a pass closes with the flag still zero
  wire bulkRunD = resetActive ? 1'b0 :
                  (bulkHeadCheck ? bulkFilledQ :
                  ((bulkPassEnd && !bulkFilledQ && !bulkSet) ? 1'b0 : bulkRunQ));
  wire ctrlRunD = resetActive ? 1'b0 :
                  (ctrlHeadCheck ? ctrlFilledQ :
                  ((ctrlPassEnd && !ctrlFilledQ && !ctrlSet) ? 1'b0 : ctrlRunQ));

  // ****************************************************************
  // Flip-flops
  // ****************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tallyQ      <= 2'h0;
      ownerReqQ   <= 1'b0;
      bulkFilledQ <= 1'b0;
      ctrlFilledQ <= 1'b0;
      softResetQ  <= 1'b0;
      bulkRunQ    <= 1'b0;
      ctrlRunQ    <= 1'b0;
      overrunQ    <= 1'b0;
      ownerEvtQ   <= 1'b0;
    end else begin
      tallyQ      <= tallyD;
      ownerReqQ   <= ownerReqD;
      bulkFilledQ <= bulkFilledD;
      ctrlFilledQ <= ctrlFilledD;
      softResetQ  <= softResetD;
      bulkRunQ    <= bulkRunD;
      ctrlRunQ    <= ctrlRunD;
      overrunQ    <= overrunHit;
      ownerEvtQ   <= ownerRise;
    end
  end

  // ****************************************************************
  // Soft reset sequencer
  // ****************************************************************
  ocs_soft_reset #(
    .RESET_CYCLES (RESET_CYCLES)
  ) uSoftReset (
    .mclk        (mclk),
    .arst_n      (arst_n),
    .start       (resetStart),
    .resetActive (resetActive),
    .resetDone   (resetDone)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign regRdata = {14'h0000, tallyQ, 12'h000, ownerReqQ, bulkFilledQ,
                     ctrlFilledQ, softResetQ};
  assign bulkProcess      = bulkRunQ;
  assign ctrlProcess      = ctrlRunQ;
  assign overrunEvent     = overrunQ;
  assign ownerChangeEvent = ownerEvtQ;
  assign softResetActive  = softResetQ;
  assign hostBusBlock     = softResetQ;
  assign suspendedEnter   = resetActive;
  assign rootHubReset     = 1'b0;

endmodule : ocs_command_status

// >>> ocs_command_status_properties.sv
// Concurrent checks for the command and status register
`timescale 1ns/1ps
module ocs_command_status_properties #(
  parameter int RESET_CYCLES = 16
) (
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        regWrite,
  input wire logic [31:0] regWdata,
  input wire logic [31:0] regRdata,
  input wire logic        frameEnd,
  input wire logic        periodicDone,
  input wire logic        handoverDone,
  input wire logic        bulkHeadCheck,
  input wire logic        bulkTdFound,
  input wire logic        bulkPassEnd,
  input wire logic        ctrlHeadCheck,
  input wire logic        ctrlTdFound,
  input wire logic        ctrlPassEnd,
  input wire logic        bulkProcess,
  input wire logic        ctrlProcess,
  input wire logic        overrunEvent,
  input wire logic        ownerChangeEvent,
  input wire logic        softResetActive,
  input wire logic        hostBusBlock,
  input wire logic        suspendedEnter,
  input wire logic        rootHubReset
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence sQuiet; !regWrite && !softResetActive; endsequence
  sequence sOverrun; frameEnd && !periodicDone; endsequence
  property pHead(h, f, td, run); h && f && !td ##0 sQuiet |=> run && !f; endproperty
  property pRefill(td, f, run); run && td ##0 sQuiet |=> f; endproperty
  property pStop(p, f, td, run); p && !f && !td ##0 sQuiet |=> !run; endproperty
  a_tally_counts: assert property (sOverrun |=> regRdata[17:16] == 2'($past(regRdata[17:16]) + 2'h1))
    else $error("tally did not advance by one");
  a_overrun_flag: assert property (sOverrun |=> overrunEvent)
    else $error("overrun event missing");
  a_owner_flag: assert property ($rose(regRdata[3]) |-> ##[0:1] ownerChangeEvent)
    else $error("owner change event missing");
  a_owner_clear: assert property (handoverDone && !(regWrite && regWdata[3]) |=> !regRdata[3])
    else $error("owner request not cleared");
  a_write_sets: assert property (regWrite && !regWdata[0] && !softResetActive
    |=> (regRdata[3:1] & $past(regWdata[3:1])) == $past(regWdata[3:1]))
    else $error("written one did not set");
  a_reserved_zero: assert property ((regRdata & 32'hFFFC_FFF0) == 32'h0000_0000)
    else $error("reserved bits not zero");
  a_bus_block: assert property (hostBusBlock == regRdata[0] && softResetActive == regRdata[0])
    else $error("bus block differs from reset bit");
  a_reset_bound: assert property ($rose(regRdata[0]) |-> ##[1:500] !regRdata[0])
    else $error("soft reset too long");
  a_suspend_entry: assert property ($rose(regRdata[0]) |-> ##[0:1] suspendedEnter)
    else $error("suspend not entered");
  a_root_hub: assert property (!rootHubReset)
    else $error("root hub reset driven");
  a_bulk_head: assert property (pHead(bulkHeadCheck, regRdata[2], bulkTdFound, bulkProcess))
    else $error("bulk head start wrong");
  a_bulk_refill: assert property (pRefill(bulkTdFound, regRdata[2], bulkProcess))
    else $error("bulk refill missing");
  a_bulk_stop: assert property (pStop(bulkPassEnd, regRdata[2], bulkTdFound, bulkProcess))
    else $error("bulk did not stop");
  a_ctrl_head: assert property (pHead(ctrlHeadCheck, regRdata[1], ctrlTdFound, ctrlProcess))
    else $error("control head start wrong");
  a_ctrl_refill: assert property (pRefill(ctrlTdFound, regRdata[1], ctrlProcess))
    else $error("control refill missing");
  a_ctrl_stop: assert property (pStop(ctrlPassEnd, regRdata[1], ctrlTdFound, ctrlProcess))
    else $error("control did not stop");
endmodule : ocs_command_status_properties

bind ocs_command_status ocs_command_status_properties #(.RESET_CYCLES(RESET_CYCLES)) uProps (.*);

// >>> ocs_command_status_tb.sv
// Directed testbench for the command and status register
`timescale 1ns/1ps
module ocs_command_status_tb;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic        regWrite = 1'b0;
  logic [31:0] regWdata = 32'h0000_0000;
  logic        periodicDone = 1'b1;
  logic [7:0]  ev = 8'h00;
  wire  [31:0] rd;
  wire  [7:0]  ob;
  int          err_total = 0, total_checks = 0, cyc = 0, ovCnt = 0, ocCnt = 0;

  ocs_command_status #(.RESET_CYCLES(2)) DUT (.mclk(mclk), .arst_n(arst_n), .regWrite(regWrite),
    .regWdata(regWdata), .regRdata(rd), .frameEnd(ev[0]), .periodicDone(periodicDone), .handoverDone(ev[1]),
    .bulkHeadCheck(ev[2]), .bulkTdFound(ev[3]), .bulkPassEnd(ev[4]), .ctrlHeadCheck(ev[5]),
    .ctrlTdFound(ev[6]), .ctrlPassEnd(ev[7]), .bulkProcess(ob[0]), .ctrlProcess(ob[1]), .overrunEvent(ob[2]),
    .ownerChangeEvent(ob[3]), .softResetActive(ob[4]), .hostBusBlock(ob[5]), .suspendedEnter(ob[6]),
    .rootHubReset(ob[7]));

  always #10 mclk = ~mclk;

  // Event pulse counters and hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (ob[2] === 1'b1) ovCnt <= ovCnt + 1;
    if (ob[3] === 1'b1) ocCnt <= ocCnt + 1;
    if (cyc == 2000) begin
      err_total++;
      wrap_up();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [31:0] d);
    @(posedge mclk);
    regWrite <= 1'b1;
    regWdata <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
    #1;
  endtask : wr

  task pulse(input int i);
    @(posedge mclk);
    ev <= 8'(1 << i);
    @(posedge mclk);
    ev <= 8'h00;
    #1;
  endtask : pulse

  task wrap_up;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int b, e, n;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    #1;
    chk(rd, 32'h0000_0000);
    wr(32'hFFFC_FFF0); chk(rd, 32'h0000_0000);
    for (int l = 0; l < 2; l++) begin
      b = 2 - l;
      e = 2 + 3 * l;
      pulse(e); chk(ob[l], 1'b0);
      wr(32'(1 << b)); chk(rd, 32'(1 << b));
      pulse(e); chk({rd[b], ob[l]}, 2'b01);
      pulse(e + 1); chk(rd[b], 1'b1);
      pulse(e + 2); chk(ob[l], 1'b1);
      pulse(e); pulse(e + 2); chk(ob[l], 1'b0);
    end
    wr(32'h0000_0006); wr(32'h0000_0002); wr(32'h0000_0000); chk(rd, 32'h0000_0006);
    periodicDone <= 1'b0;
    for (int k = 1; k < 6; k++) begin
      pulse(0); chk(rd >> 16, k & 3);
    end
    periodicDone <= 1'b1;
    pulse(0); chk(rd >> 16, 1);
    wr(32'h0000_0008); chk(rd[3], 1'b1);
    pulse(1); wr(32'h0000_0000); chk(rd[3], 1'b0);
    chk(ocCnt, 1);
    chk(ovCnt, 5);
    wr(32'h0000_0007); chk(ob[5:4], 2'b11);
    chk(ob[6], 1'b1);
    n = 0;
    while (rd[0] === 1'b1 && n < 600) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(n <= 500, 1);
    chk(rd, 32'h0001_0000);
    chk(ob[7], 1'b0);
    wrap_up();
  end
endmodule : ocs_command_status_tb
